// ==== rtl/flash_seq_regs.vh ====
// Constants for the serial flash write sequencer.
`ifndef FLASH_SEQ_REGS_VH
`define FLASH_SEQ_REGS_VH

`define CLK_HZ                 125000000
`define CYC_PER_US             (`CLK_HZ / 1000000)
`define CYC_PER_MS             (`CLK_HZ / 1000)
`define CYC_PER_S              `CLK_HZ

`define BYTE_PROGRAM_TIME_US   50
`define SECTOR_ERASE_TIME_MS   200
`define BLOCK_ERASE_TIME_MS    500
`define ARRAY_ERASE_TIME_S     4
`define STATUS_WRITE_TIME_MS   60

`define ARRAY_BYTES            131072
`define ADDR_BITS              17
`define SECTOR_BITS            12
`define BLOCK_BITS             15
`define PAGE_BITS              8

`define OPC_SET_WRITE_LATCH    8'h06
`define OPC_CLEAR_WRITE_LATCH  8'h04
`define OPC_STATUS_READ        8'h05
`define OPC_STATUS_WRITE       8'h01
`define OPC_READ               8'h03
`define OPC_FAST_READ          8'h0b
`define OPC_PROGRAM            8'h02
`define OPC_SECTOR_ERASE_A     8'h20
`define OPC_SECTOR_ERASE_B     8'hd7
`define OPC_BLOCK_ERASE_A      8'h52
`define OPC_BLOCK_ERASE_B      8'hd8
`define OPC_ARRAY_ERASE_A      8'h60
`define OPC_ARRAY_ERASE_B      8'hc7
`define OPC_IDENTITY_A         8'h9f
`define OPC_IDENTITY_B         8'hab

`define SR_BUSY_BIT            0
`define SR_WEL_BIT             1
`define SR_PROT_LSB            2
`define SR_PROT_MSB            4
`define SR_WPEN_BIT            7
`define SR_PROT_RESET          3'h0
`define SR_WPEN_RESET          1'b0

`endif

// ==== rtl/flash_array.v ====
// Byte-wide storage array with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module flash_array #(
   parameter AW = 17,
   parameter DW = 8
) (
   input  wire          clk,    // Block clock.
   input  wire          we,     // Write strobe.
   input  wire [AW-1:0] addr,   // Byte address.
   input  wire [DW-1:0] wdata,  // Write data.
   output reg  [DW-1:0] rdata   // Read data, one cycle after addr.
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule
`default_nettype wire

// ==== rtl/serial_flash_write_sequencer.v ====
// Serial flash slave: command decoder, protection and timed write engine.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_regs.vh"
module serial_flash_write_sequencer #(
   parameter [31:0] BYTE_PROG_CYC   = `BYTE_PROGRAM_TIME_US * `CYC_PER_US,
   parameter [31:0] SECTOR_ERA_CYC  = `SECTOR_ERASE_TIME_MS * `CYC_PER_MS,
   parameter [31:0] BLOCK_ERA_CYC   = `BLOCK_ERASE_TIME_MS * `CYC_PER_MS,
   parameter [31:0] ARRAY_ERA_CYC   = `ARRAY_ERASE_TIME_S * `CYC_PER_S,
   parameter [31:0] STATUS_WR_CYC   = `STATUS_WRITE_TIME_MS * `CYC_PER_MS,
   parameter [7:0]  MFR_CODE        = 8'h5a,   // Arbitrary value.
   parameter [15:0] DEV_CODE        = 16'h3c01 // Arbitrary value.
) (
   input  wire CLOCK,       // Block clock, 125 MHz.
   input  wire RST_N,       // Asynchronous reset, active low.
   input  wire CS_N,        // Chip select pin, active low.
   input  wire SCK,         // Serial clock pin from the master.
   input  wire SI,          // Serial data in.
   input  wire HOLD_N,      // Hold pin, active low.
   input  wire WP_N,        // Write-protect pin, active low.
   output reg  SO_OUT,      // Serial data out level.
   output reg  SO_OE_N,     // Serial out enable, low while driving.
   output reg  BUSY,        // Self-timed write cycle running.
   output reg  WRITE_LATCH  // Write enable latch.
);
   localparam AW = `ADDR_BITS;
   localparam [17:0] ARR = `ARRAY_BYTES;
   localparam [7:0] ST_CMD = 8'h01, ST_ADDR = 8'h02, ST_DUMMY = 8'h04,
                    ST_DATA = 8'h08, ST_STAT = 8'h10, ST_OUT = 8'h20,
                    ST_WAIT = 8'h40, ST_IGN = 8'h80;
   localparam [2:0] OP_NONE = 3'd0, OP_PROG = 3'd1, OP_SE = 3'd2,
                    OP_BE = 3'd3, OP_CE = 3'd4, OP_SR = 3'd5,
                    OP_READ = 3'd6, OP_FAST = 3'd7;
   localparam [1:0] OUT_STAT = 2'd0, OUT_DATA = 2'd1, OUT_ID = 2'd2;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; edges are found between stage two and three.
   reg  [4:0]    pin_q1_r;
   reg  [4:0]    pin_q2_r;
   reg           cs_n_d_r;
   reg           sck_d_r;
   wire          cs_n_s   = pin_q2_r[4];
   wire          sck_s    = pin_q2_r[3];
   wire          si_s     = pin_q2_r[2];
   wire          hold_n_s = pin_q2_r[1];
   wire          wp_n_s   = pin_q2_r[0];

   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         pin_q1_r <= 5'h1f;
         pin_q2_r <= 5'h1f;
         cs_n_d_r <= 1'b1;
         sck_d_r  <= 1'b0;
      end else begin
         pin_q1_r <= {CS_N, SCK, SI, HOLD_N, WP_N};
         pin_q2_r <= pin_q1_r;
         cs_n_d_r <= cs_n_s;
         sck_d_r  <= sck_s;
      end
   end

   wire cs_fall = cs_n_d_r & ~cs_n_s;
   wire cs_rise = ~cs_n_d_r & cs_n_s;
   // Edges count only while selected and not held.
   wire active   = ~cs_n_s & hold_n_s & ~cs_fall;
   // Input sampled on rising, output changed on falling: modes 0 and 3.
   wire sck_rise = active & sck_s & ~sck_d_r;
   wire sck_fall = active & ~sck_s & sck_d_r;

   ////////////////////////////////////////////////////////////////////////
   // State registers.
   reg  [7:0]    state_r;
   reg  [2:0]    op_r;
   reg  [2:0]    pend_r;
   reg  [1:0]    out_kind_r;
   reg  [6:0]    rx_r;
   reg  [2:0]    bit_cnt_r;
   reg  [2:0]    tx_cnt_r;
   reg  [6:0]    tx_sh_r;
   reg  [1:0]    idx_r;
   reg  [23:0]   addr_r;
   reg  [AW-1:0] rd_addr_r;
   reg  [AW-1:0] pa_r;
   reg  [8:0]    prog_cnt_r;
   reg           prog_we_r;
   reg  [AW-1:0] prog_wa_r;
   reg  [7:0]    prog_wd_r;
   reg  [2:0]    prot_r;
   reg           wpen_r;
   reg  [7:0]    sr_new_r;
   reg  [2:0]    run_op_r;
   reg  [31:0]   timer_r;
   reg           sweep_r;
   reg  [AW-1:0] sweep_addr_r;
   reg  [AW-1:0] sweep_last_r;
   wire [7:0]    rd_data;

   wire [7:0]    rx_byte   = {rx_r, si_s};
   wire          byte_done = sck_rise & (bit_cnt_r == 3'd7);
   wire [AW-1:0] full_addr = {addr_r[AW-9:0], rx_byte};
   wire [31:0]   prog_load = prog_cnt_r * BYTE_PROG_CYC;

   function [17:0] prot_base;
      input [2:0] bp;
      begin
         case (bp)
            3'd0:    prot_base = ARR;
            3'd1:    prot_base = ARR - (ARR >> 5);
            3'd2:    prot_base = ARR - (ARR >> 4);
            3'd3:    prot_base = ARR - (ARR >> 3);
            3'd4:    prot_base = ARR - (ARR >> 2);
            3'd5:    prot_base = ARR - (ARR >> 1);
            default: prot_base = 18'h00000;
         endcase
      end
   endfunction

   // Protected region is the upper fraction named by prot_r.
   wire [17:0] base = prot_base(prot_r);
   wire pa_prot = ({1'b0, pa_r} >= base);

   reg [AW-1:0] er_first;
   reg [AW-1:0] er_last;
   reg [31:0]   er_load;
   always @* begin
      er_first = {AW{1'b0}};
      er_last  = {AW{1'b1}};
      er_load  = ARRAY_ERA_CYC;
      case (pend_r)
         OP_SE: begin
            er_first = {addr_r[AW-1:`SECTOR_BITS], {`SECTOR_BITS{1'b0}}};
            er_last  = {addr_r[AW-1:`SECTOR_BITS], {`SECTOR_BITS{1'b1}}};
            er_load  = SECTOR_ERA_CYC;
         end
         OP_BE: begin
            er_first = {addr_r[AW-1:`BLOCK_BITS], {`BLOCK_BITS{1'b0}}};
            er_last  = {addr_r[AW-1:`BLOCK_BITS], {`BLOCK_BITS{1'b1}}};
            er_load  = BLOCK_ERA_CYC;
         end
         default: begin
         end
      endcase
   end
   wire er_prot = ({1'b0, er_last} >= base);

   reg [7:0] status_byte;
   always @* begin
      status_byte = 8'h00;
      status_byte[`SR_BUSY_BIT] = BUSY;
      status_byte[`SR_WEL_BIT]  = WRITE_LATCH;
      status_byte[`SR_PROT_MSB:`SR_PROT_LSB] = prot_r;
      status_byte[`SR_WPEN_BIT] = wpen_r;
   end

   reg [7:0] next_out;
   always @* begin
      case (out_kind_r)
         OUT_DATA: next_out = rd_data;
         OUT_ID: begin
            case (idx_r)
               2'd0:    next_out = MFR_CODE;
               2'd1:    next_out = DEV_CODE[15:8];
               2'd2:    next_out = DEV_CODE[7:0];
               default: next_out = 8'h00;
            endcase
         end
         default: next_out = status_byte;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial protocol, write latch and timed write engine.
   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state_r      <= ST_IGN;
         op_r         <= OP_NONE;
         pend_r       <= OP_NONE;
         out_kind_r   <= OUT_STAT;
         rx_r         <= 7'h00;
         bit_cnt_r    <= 3'd0;
         tx_cnt_r     <= 3'd0;
         tx_sh_r      <= 7'h00;
         idx_r        <= 2'd0;
         addr_r       <= 24'h000000;
         rd_addr_r    <= {AW{1'b0}};
         pa_r         <= {AW{1'b0}};
         prog_cnt_r   <= 9'd0;
         prog_we_r    <= 1'b0;
         prog_wa_r    <= {AW{1'b0}};
         prog_wd_r    <= 8'h00;
         prot_r       <= `SR_PROT_RESET;
         wpen_r       <= `SR_WPEN_RESET;
         sr_new_r     <= 8'h00;
         run_op_r     <= OP_NONE;
         timer_r      <= 32'd0;
         sweep_r      <= 1'b0;
         sweep_addr_r <= {AW{1'b0}};
         sweep_last_r <= {AW{1'b0}};
         SO_OUT       <= 1'b0;
         SO_OE_N      <= 1'b1;
         BUSY         <= 1'b0;
         WRITE_LATCH  <= 1'b0;
      end else begin
         prog_we_r <= 1'b0;
         SO_OE_N   <= ~(~cs_n_s & hold_n_s & (state_r == ST_OUT));
         if (cs_fall) begin
            state_r    <= ST_CMD;
            pend_r     <= OP_NONE;
            bit_cnt_r  <= 3'd0;
            tx_cnt_r   <= 3'd0;
            idx_r      <= 2'd0;
            prog_cnt_r <= 9'd0;
         end
         if (sck_rise) begin
            rx_r      <= rx_byte[6:0];
            bit_cnt_r <= bit_cnt_r + 3'd1;
         end
         if (byte_done) begin
            case (state_r)
               ST_CMD: begin
                  state_r <= ST_IGN;
                  if (BUSY && rx_byte != `OPC_STATUS_READ) begin
                     state_r <= ST_IGN;
                  end else begin
                     case (rx_byte)
                        `OPC_SET_WRITE_LATCH:   WRITE_LATCH <= 1'b1;
                        `OPC_CLEAR_WRITE_LATCH: WRITE_LATCH <= 1'b0;
                        `OPC_STATUS_READ: begin
                           out_kind_r <= OUT_STAT;
                           state_r    <= ST_OUT;
                        end
                        `OPC_STATUS_WRITE:
                           if (WRITE_LATCH) state_r <= ST_STAT;
                        `OPC_READ, `OPC_FAST_READ: begin
                           op_r    <= (rx_byte == `OPC_READ) ? OP_READ
                                                             : OP_FAST;
                           state_r <= ST_ADDR;
                        end
                        `OPC_PROGRAM: begin
                           op_r <= OP_PROG;
                           if (WRITE_LATCH) state_r <= ST_ADDR;
                        end
                        `OPC_SECTOR_ERASE_A, `OPC_SECTOR_ERASE_B: begin
                           op_r <= OP_SE;
                           if (WRITE_LATCH) state_r <= ST_ADDR;
                        end
                        `OPC_BLOCK_ERASE_A, `OPC_BLOCK_ERASE_B: begin
                           op_r <= OP_BE;
                           if (WRITE_LATCH) state_r <= ST_ADDR;
                        end
                        `OPC_ARRAY_ERASE_A, `OPC_ARRAY_ERASE_B: begin
                           if (WRITE_LATCH) begin
                              pend_r  <= OP_CE;
                              state_r <= ST_WAIT;
                           end
                        end
                        `OPC_IDENTITY_A, `OPC_IDENTITY_B: begin
                           out_kind_r <= OUT_ID;
                           state_r    <= ST_OUT;
                        end
                        default: state_r <= ST_IGN;
                     endcase
                  end
               end
               ST_ADDR: begin
                  addr_r <= {addr_r[15:0], rx_byte};
                  idx_r  <= idx_r + 2'd1;
                  if (idx_r == 2'd2) begin
                     idx_r      <= 2'd0;
                     rd_addr_r  <= full_addr;
                     pa_r       <= full_addr;
                     out_kind_r <= OUT_DATA;
                     case (op_r)
                        OP_READ:  state_r <= ST_OUT;
                        OP_FAST:  state_r <= ST_DUMMY;
                        OP_PROG:  state_r <= ST_DATA;
                        default: begin
                           pend_r  <= op_r;
                           state_r <= ST_WAIT;
                        end
                     endcase
                  end
               end
               ST_DUMMY: state_r <= ST_OUT;
               ST_DATA: begin
                  // Bytes go to the array as they arrive; reads are refused until the timed
                  // cycle ends, and a frame cut off a byte boundary starts no cycle and leaves them readable.
                  pend_r <= OP_PROG;
                  pa_r[`PAGE_BITS-1:0] <= pa_r[`PAGE_BITS-1:0] + 8'h01;
                  if (!pa_prot && prog_cnt_r != 9'd256) begin
                     prog_we_r  <= 1'b1;
                     prog_wa_r  <= pa_r;
                     prog_wd_r  <= rx_byte;
                     prog_cnt_r <= prog_cnt_r + 9'd1;
                  end
               end
               ST_STAT: begin
                  sr_new_r <= rx_byte;
                  pend_r   <= OP_SR;
                  state_r  <= ST_WAIT;
               end
               default: begin
               end
            endcase
         end
         if (sck_fall && state_r == ST_OUT) begin
            tx_cnt_r <= tx_cnt_r + 3'd1;
            if (tx_cnt_r == 3'd0) begin
               SO_OUT  <= next_out[7];
               tx_sh_r <= next_out[6:0];
               if (out_kind_r == OUT_DATA) rd_addr_r <= rd_addr_r + 17'd1;
               if (out_kind_r == OUT_ID && idx_r != 2'd3) begin
                  idx_r <= idx_r + 2'd1;
               end
            end else begin
               SO_OUT  <= tx_sh_r[6];
               tx_sh_r <= {tx_sh_r[5:0], 1'b0};
            end
         end
         // A write starts only when select rises on a byte boundary.
         if (cs_rise) begin
            state_r <= ST_IGN;
            if (bit_cnt_r == 3'd0 && !BUSY) begin
               run_op_r <= pend_r;
               case (pend_r)
                  OP_PROG: if (prog_cnt_r != 9'd0) begin
                     BUSY    <= 1'b1;
                     timer_r <= prog_load;
                  end
                  OP_SE, OP_BE, OP_CE: if (!er_prot) begin
                     BUSY         <= 1'b1;
                     timer_r      <= er_load;
                     sweep_r      <= 1'b1;
                     sweep_addr_r <= er_first;
                     sweep_last_r <= er_last;
                  end
                  OP_SR: if (!(wpen_r && !wp_n_s)) begin
                     BUSY    <= 1'b1;
                     timer_r <= STATUS_WR_CYC;
                  end
                  default: begin
                  end
               endcase
            end
         end
         if (sweep_r) begin
            sweep_addr_r <= sweep_addr_r + 17'd1;
            if (sweep_addr_r == sweep_last_r) sweep_r <= 1'b0;
         end
         if (BUSY) begin
            if (timer_r > 32'd1) begin
               timer_r <= timer_r - 32'd1;
            end else if (!sweep_r) begin
               BUSY        <= 1'b0;
               WRITE_LATCH <= 1'b0;
               if (run_op_r == OP_SR) begin
                  // Erase and program of the status bits in one step.
                  prot_r <= sr_new_r[`SR_PROT_MSB:`SR_PROT_LSB];
                  wpen_r <= sr_new_r[`SR_WPEN_BIT];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Array port: erase sweep, then program write, else read address.
   wire          mem_we    = sweep_r | prog_we_r;
   wire [AW-1:0] mem_addr  = sweep_r ? sweep_addr_r :
                             prog_we_r ? prog_wa_r : rd_addr_r;
   wire [7:0]    mem_wdata = sweep_r ? 8'hff : prog_wd_r;

   flash_array #(.AW(AW), .DW(8)) u_array (
      .clk   (CLOCK),
      .we    (mem_we),
      .addr  (mem_addr),
      .wdata (mem_wdata),
      .rdata (rd_data)
   );
endmodule
`default_nettype wire

// ==== verif/serial_flash_write_sequencer_asserts.sv ====
// Pin-level checks for the serial flash write sequencer.
`timescale 1ns/1ps
`default_nettype none
module flash_seq_asserts #(
   parameter [31:0] BYTE_PROG_CYC = 32'h186a,
   parameter [31:0] STATUS_WR_CYC = 32'h7270e0,
   parameter [31:0] ARRAY_ERA_CYC = 32'h1dcd6500
) (
   input wire logic CLOCK,       // Block clock.
   input wire logic RST_N,       // Reset, active low.
   input wire logic CS_N,        // Chip select, active low.
   input wire logic SCK,         // Serial clock pin.
   input wire logic SI,          // Serial data in.
   input wire logic HOLD_N,      // Hold pin, active low.
   input wire logic WP_N,        // Write-protect pin, active low.
   input wire logic SO_OUT,      // Serial out level.
   input wire logic SO_OE_N,     // Serial out enable, active low.
   input wire logic BUSY,        // Timed write cycle running.
   input wire logic WRITE_LATCH  // Write enable latch.
);
   localparam [31:0] MIN_CYC = (BYTE_PROG_CYC < STATUS_WR_CYC) ?
                               BYTE_PROG_CYC : STATUS_WR_CYC;
   // Loose ceiling: it only has to catch a cycle that never ends.
   localparam [31:0] MAX_CYC = ARRAY_ERA_CYC + 32'h20000 +
                               256 * BYTE_PROG_CYC + STATUS_WR_CYC;
   logic [31:0] busy_cnt_r;
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N)
         busy_cnt_r <= 32'h0;
      else if (BUSY)
         busy_cnt_r <= busy_cnt_r + 32'h1;
      else
         busy_cnt_r <= 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);
   sequence deselected_s;
      CS_N [*5];
   endsequence
   sequence held_s;
      (!HOLD_N) [*5];
   endsequence
   a_so_released: assert property (deselected_s |-> SO_OE_N)
      else $error("serial out driven while deselected");
   a_hold_quiet: assert property (held_s |-> SO_OE_N)
      else $error("serial out driven during hold");
   a_busy_latch: assert property ($rose(BUSY) |-> WRITE_LATCH)
      else $error("write cycle started without the latch");
   a_busy_after_cs: assert property ($rose(BUSY) |-> CS_N)
      else $error("write cycle started while selected");
   a_latch_clears: assert property ($fell(BUSY) |-> !WRITE_LATCH)
      else $error("latch still set after write cycle");
   a_busy_min_len: assert property ($fell(BUSY) |-> busy_cnt_r >= MIN_CYC)
      else $error("write cycle shorter than its time");
   a_busy_bounded: assert property (BUSY |-> busy_cnt_r <= MAX_CYC)
      else $error("write cycle runs too long");
   a_latch_frozen: assert property (BUSY && $past(BUSY) |-> $stable(WRITE_LATCH))
      else $error("latch changed during write cycle");
   a_latch_set: assert property ($rose(WRITE_LATCH) |-> !CS_N && !$past(BUSY))
      else $error("latch set outside a selected idle frame");
   a_latch_drop: assert property ($fell(WRITE_LATCH) |-> !CS_N || $fell(BUSY))
      else $error("latch cleared without cause");
endmodule
bind serial_flash_write_sequencer flash_seq_asserts #(
   .BYTE_PROG_CYC(BYTE_PROG_CYC),
   .STATUS_WR_CYC(STATUS_WR_CYC),
   .ARRAY_ERA_CYC(ARRAY_ERA_CYC)
) chk_u (
   .CLOCK(CLOCK), .RST_N(RST_N), .CS_N(CS_N), .SCK(SCK), .SI(SI),
   .HOLD_N(HOLD_N), .WP_N(WP_N), .SO_OUT(SO_OUT), .SO_OE_N(SO_OE_N),
   .BUSY(BUSY), .WRITE_LATCH(WRITE_LATCH)
);
`default_nettype wire

// ==== verif/spi_master_model.sv ====
// Serial master model driving the link pins of the flash slave.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
   output var logic cs_n,    // Chip select, active low.
   output var logic sck,     // Serial clock, 125 ns period.
   output var logic si,      // Serial data to the slave.
   output var logic hold_n,  // Hold, active low.
   input  wire logic so      // Resolved serial data from the slave.
);
   logic mode3;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
      mode3 = 1'b0;
   end
   // The odd offset keeps link edges off the block clock edges.
   task start(input logic m);
      mode3 = m;
      sck = m;
      #63.8;
      cs_n = 1'b0;
      #62.5;
   endtask
   task xb(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         si = tx[i];
         #62.5;
         sck = 1'b1;
         rx[i] = so;
         #62.5;
      end
   endtask
   task pause;
      sck = 1'b0;
      #62.5;
      hold_n = 1'b0;
      repeat (4) begin
         sck = ~sck;
         si = ~si;
         #62.5;
      end
      hold_n = 1'b1;
      #62.5;
   endtask
   // A released data line must not keep its last level.
   task stop;
      if (!mode3)
         sck = 1'b0;
      #62.5;
      cs_n = 1'b1;
      si = ~si;
      #120;
   endtask
endmodule
`default_nettype wire

// ==== verif/serial_flash_write_sequencer_tb.sv ====
// Self-checking bench for the serial flash write sequencer.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_write_sequencer_tb;
   localparam int BPC = 20;
   localparam int SWC = 30;
   localparam logic [23:0] ID_VAL = 24'h6b2e07; // Arbitrary value.
   logic        clk, rst_n, wp_n;
   wire logic   cs_n, sck, si, hold_n, so_w;
   wire logic   so_out, so_oe_n, busy, wlatch;
   int          n_fail = 0;
   int          checks_done = 0;
   int          brun = 0;
   int          blast = 0;
   logic [63:0] rx;
   always #4 clk = ~clk;
   assign so_w = so_oe_n ? 1'bz : so_out;
   spi_master_model m_u (.cs_n(cs_n), .sck(sck), .si(si),
      .hold_n(hold_n), .so(so_w));
   serial_flash_write_sequencer #(.BYTE_PROG_CYC(BPC),
      .SECTOR_ERA_CYC(50), .BLOCK_ERA_CYC(60), .ARRAY_ERA_CYC(80),
      .STATUS_WR_CYC(SWC), .MFR_CODE(ID_VAL[23:16]),
      .DEV_CODE(ID_VAL[15:0])) dut_u (.CLOCK(clk), .RST_N(rst_n),
      .CS_N(cs_n), .SCK(sck), .SI(si), .HOLD_N(hold_n), .WP_N(wp_n),
      .SO_OUT(so_out), .SO_OE_N(so_oe_n), .BUSY(busy),
      .WRITE_LATCH(wlatch));
   // Length of the last write cycle in clocks.
   always @(negedge clk) begin
      if (busy === 1'b1)
         brun <= brun + 1;
      else begin
         if (brun != 0)
            blast <= brun;
         brun <= 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task chkb(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task chkd(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task run(input logic [63:0] v, input int n, input logic m3 = 1'b0,
            input int hp = -1);
      logic [7:0] b;
      @(negedge clk);
      m_u.start(m3);
      rx = '0;
      for (int i = n - 1; i >= 0; i--) begin
         if (i == hp)
            m_u.pause();
         m_u.xb(v[8*i +: 8], b);
         rx[8*i +: 8] = b;
      end
      m_u.stop();
   endtask
   task settle;
      int k;
      k = 0;
      // Long enough for a whole block sweep at the bench's short timers.
      while (busy !== 1'b0 && k < 40000) begin
         @(negedge clk);
         k++;
      end
      chkb(busy, 1'b0);
      repeat (2) @(negedge clk);
   endtask
   task wrap_up;
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      wp_n = 1'b1;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chkb(wlatch, 1'b0);
      chkb(busy, 1'b0);
      for (int i = 0; i < 2; i++) begin
         run({(i == 0) ? 8'h9f : 8'hab, 24'h0}, 4, i[0]);
         chkd(rx[23:0], ID_VAL);
      end
      run(8'h06, 1);
      chkb(wlatch, 1'b1);
      run(8'h04, 1, 1'b1);
      chkb(wlatch, 1'b0);
      run(40'h02000010aa, 5);
      chkb(busy, 1'b0);
      run(8'h06, 1);
      run(32'h20000000, 4);
      chkb(busy, 1'b1);
      run(8'h04, 1);
      run(16'h0500, 2);
      chkd(rx[7:0], 8'h03);
      settle;
      chkb(wlatch, 1'b0);
      chkb(blast >= 4096 && blast < 4200, 1'b1);
      // Three bytes from the page's last two places wrap to its start.
      run(8'h06, 1);
      run(56'h020000fea1b2c3, 7);
      settle;
      chkd(blast, 3 * BPC);
      chkb(wlatch, 1'b0);
      run(56'h030000fe000000, 7, 1'b0, 4);
      chkd(rx[23:0], 24'ha1b2ff);
      run(48'h0b0000000000, 6, 1'b1);
      chkd(rx[7:0], 8'hc3);
      run(8'h06, 1);
      run(16'h0194, 2);
      settle;
      chkd(blast, SWC);
      run(16'h0500, 2);
      chkd(rx[7:0], 8'h94);
      @(negedge clk);
      wp_n = 1'b0;
      run(8'h06, 1);
      run(16'h0100, 2);
      chkb(busy, 1'b0);
      run(40'h0201ff0055, 5);
      chkb(busy, 1'b0);
      run(16'h0500, 2);
      chkd(rx[7:0], 8'h96);
      // A whole-array erase overlaps the protected half and is dropped.
      run(8'h06, 1);
      run(8'hc7, 1);
      chkb(busy, 1'b0);
      // The lowest block lies outside the protected half and is erased.
      run(32'hd8000000, 4);
      chkb(busy, 1'b1);
      settle;
      chkb(blast >= 32768 && blast < 32900, 1'b1);
      run(40'h030000fe00, 5);
      chkd(rx[7:0], 8'hff);
      run(16'h0500, 2);
      chkd(rx[7:0], 8'h94);
      wrap_up;
   end
   initial begin
      #500000;
      n_fail++;
      wrap_up;
   end
endmodule
`default_nettype wire
